// >>> design/acc_adc_control.sv
// Summary of operation
// - Channel select is a 4-bit read/write register at 14H with its top bit tied to zero.
// - Channel codes 0 to 5 route analog inputs 0 to 5 to the comparator.
// - Channel codes 6 and 7 route nothing and leave every shared pin a plain input.
// - At most one shared pin reaches the converter at any time.
// - Every shared pin not selected stays readable as a general-purpose input.
// - A first-port pin loses its pull-down as soon as it is selected.
// - Every unselected first-port pin keeps its pull-down.
// - The comparator outcome is readable through the compare judge register at 06H.
// - The result is one bit, 1 for true and 0 for false.
// - The tap multiplexer is driven by the 6-bit compare code at peripheral 02H.
// - There are 64 compare levels, one resistor-string tap per code value.
// - The resistor string is powered only while the compare judge register is read.
// - Only the low six bits of the transfer buffer enter the compare code.
// - First-port pins are pulled down while serving as general-purpose inputs.
// - A shared input pin reads 1 when high and 0 when low.
module acc_adc_control
    import acc_pkg::*;
(
    input  wire logic                        ref_clk_i,
    input  wire logic                        rst_n_i,
    input  wire logic                        ce_reset_i,
    input  wire logic                        clock_stop_i,
    input  wire acc_rf_req_t                 rf_req_i,
    output logic [3:0]                       rf_rdata_o,
    input  wire acc_per_req_t                per_req_i,
    output logic [15:0]                      per_rdata_o,
    input  wire logic [ACC_PORT_A_WIDTH-1:0] shared_port_a_i,
    input  wire logic [ACC_PORT_B_WIDTH-1:0] shared_port_b_i,
    output logic [ACC_PORT_A_WIDTH-1:0]      shared_port_a_level_o,
    output logic [ACC_PORT_B_WIDTH-1:0]      shared_port_b_level_o,
    output logic [ACC_CHAN_COUNT-1:0]        chan_route_o,
    output logic [ACC_PORT_A_WIDTH-1:0]      pulldown_en_o,
    output logic [ACC_CODE_WIDTH-1:0]        tap_sel_o,
    output logic                             rstring_power_o,
    input  wire logic                        comparator_i
);

    // One-hot routing from a channel code; codes 6 and 7 give nothing
    function automatic logic [ACC_CHAN_COUNT-1:0] chan_onehot(
        input logic [2:0] code
    );
        logic [ACC_CHAN_COUNT-1:0] hot;
        hot = '0;
        for (int i = 0; i < ACC_CHAN_COUNT; i++) begin
            if (code == 3'(i)) begin
                hot[i] = 1'b1;
            end
        end
        return hot;
    endfunction

    logic [3:0]                 chsel_reg;
    logic [3:0]                 chsel_next;
    logic [ACC_CODE_WIDTH-1:0]  code_reg;
    logic [ACC_CODE_WIDTH-1:0]  code_next;
    logic [3:0]                 rf_rdata_reg;
    logic [3:0]                 rf_rdata_next;
    logic [15:0]                per_rdata_reg;
    logic [15:0]                per_rdata_next;
    logic [ACC_PORT_A_WIDTH-1:0] port_a_reg;
    logic [ACC_PORT_B_WIDTH-1:0] port_b_reg;

    // Address decode
    wire chsel_hit  = (rf_req_i.addr == ACC_RF_CHSEL_ADDR);
    wire judge_hit  = (rf_req_i.addr == ACC_RF_JUDGE_ADDR);
    wire code_hit   = (per_req_i.addr == ACC_PER_CODE_ADDR);
    wire chsel_wr   = rf_req_i.wr && chsel_hit;
    wire judge_rd   = rf_req_i.rd && judge_hit;
    wire code_wr    = per_req_i.wr && code_hit;
    wire soft_reset = ce_reset_i || clock_stop_i;

    // CE reset and clock stop win over a write
    assign chsel_next = soft_reset ? ACC_CHSEL_RESET
                      : chsel_wr   ? {1'b0, rf_req_i.wdata[2:0]}
                      : chsel_reg;

    // low six bits of the buffer only
    assign code_next = code_wr ? per_req_i.transfer_buffer[ACC_CODE_WIDTH-1:0]
                     : code_reg;

    // string powered only during the judge read cycle
    assign rstring_power_o = judge_rd;

    // judge result captured while the string is powered
    // single result bit, others read zero
    assign rf_rdata_next = !rf_req_i.rd ? rf_rdata_reg
                         : judge_hit    ? {3'b000, comparator_i}
                         : chsel_hit    ? chsel_reg
                         : ACC_RF_RDATA_RESET;

    // Peripheral read returns the code; unmapped reads give zero
    assign per_rdata_next = !per_req_i.rd ? per_rdata_reg
                          : code_hit ? {10'h000, code_reg}
                          : ACC_PER_RDATA_RESET;

    // Control registers; reset leaves no channel selected
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            chsel_reg <= ACC_CHSEL_RESET;
            code_reg  <= ACC_CODE_RESET;
        end else begin
            chsel_reg <= chsel_next;
            code_reg  <= code_next;
        end
    end

    // Read data and pin levels, held in flops
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rf_rdata_reg  <= ACC_RF_RDATA_RESET;
            per_rdata_reg <= ACC_PER_RDATA_RESET;
            port_a_reg    <= '0;
            port_b_reg    <= '0;
        end else begin
            rf_rdata_reg  <= rf_rdata_next;
            per_rdata_reg <= per_rdata_next;
            port_a_reg    <= shared_port_a_i;
            port_b_reg    <= shared_port_b_i;
        end
    end

    assign rf_rdata_o  = rf_rdata_reg;
    assign per_rdata_o = per_rdata_reg;

    // codes 6 and 7 route nothing
    // one-hot decode, so never two pins
    assign chan_route_o = chan_onehot(chsel_reg[2:0]);

    // tap select straight from the code register
    // six bits give all 64 taps
    assign tap_sel_o = code_reg;

    // pulled down while used as plain inputs
    genvar g;
    generate
        for (g = 0; g < ACC_PORT_A_WIDTH; g++) begin : g_pull
            assign pulldown_en_o[g] = ~chan_route_o[ACC_PORT_A_FIRST + g];
        end
    endgenerate

    // levels stay readable whatever the selection
    // high reads 1, low reads 0
    assign shared_port_a_level_o = port_a_reg;
    assign shared_port_b_level_o = port_b_reg;

    // Checks on the control paths; all in the core clock domain
    a_chsel_write: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        chsel_wr && !soft_reset |=> chsel_reg == {1'b0, $past(rf_req_i.wdata[2:0])})
        else $error("channel select did not take the write");

    a_chsel_msb: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        chsel_reg[3] == 1'b0)
        else $error("channel select top bit not zero");

    a_chan_route: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        chsel_wr && !soft_reset && rf_req_i.wdata[2:0] < 3'h6
        |=> chan_route_o == (6'h01 << $past(rf_req_i.wdata[2:0])))
        else $error("wrong channel routed");

    a_chan_unused: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        chsel_reg[2:1] == 2'b11 |-> chan_route_o == 6'h00 && pulldown_en_o == 4'hf)
        else $error("unused code routed a pin");

    a_soft_reset: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        soft_reset |=> chsel_reg[2:0] == 3'h7 && chan_route_o == 6'h00)
        else $error("soft reset left a channel selected");

    a_route_onehot: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        $onehot0(chan_route_o))
        else $error("more than one pin routed");

    a_pull_release: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        pulldown_en_o == ~chan_route_o[5:2])
        else $error("pull-down does not follow selection");

    // Second-port selection must leave every first-port pull-down on
    a_pull_port_b: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        chan_route_o[1:0] != 2'b00 |-> pulldown_en_o == 4'hf)
        else $error("pull-down released while second port selected");

    a_judge_read: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        judge_rd |=> rf_rdata_o == {3'b000, $past(comparator_i)})
        else $error("judge read returned wrong result");

    // Read data must stand until software issues the next read
    a_rdata_hold: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        !rf_req_i.rd |=> $stable(rf_rdata_o))
        else $error("register read data changed without a read");

    a_code_write: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        code_wr |=> tap_sel_o == $past(per_req_i.transfer_buffer[5:0]))
        else $error("compare code not taken from low buffer bits");

    // Tap must not move between code writes, soft reset included
    a_code_hold: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        !code_wr |=> $stable(tap_sel_o))
        else $error("tap select changed without a code write");

    a_string_power: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        rstring_power_o == (rf_req_i.rd && rf_req_i.addr == 7'h06))
        else $error("resistor string powered outside a judge read");

    a_pin_level: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        ##1 shared_port_a_level_o == $past(shared_port_a_i)
        && shared_port_b_level_o == $past(shared_port_b_i))
        else $error("pin level not reported");

endmodule

// >>> design/acc_pkg.sv
package acc_pkg;

    // Register-file offsets
    localparam logic [6:0] ACC_RF_JUDGE_ADDR  = 7'h06;
    localparam logic [6:0] ACC_RF_CHSEL_ADDR  = 7'h14;
    // Peripheral offset of the compare code register
    localparam logic [7:0] ACC_PER_CODE_ADDR  = 8'h02;

    // Field layout and widths
    localparam int         ACC_CHAN_COUNT     = 6;
    localparam int         ACC_PORT_A_WIDTH   = 4;
    localparam int         ACC_PORT_B_WIDTH   = 2;
    localparam int         ACC_PORT_A_FIRST   = 2;
    localparam int         ACC_CODE_WIDTH     = 6;
    localparam int         ACC_JUDGE_BIT      = 0;

    // Values after reset
    localparam logic [3:0] ACC_CHSEL_RESET    = 4'h7;
    localparam logic [5:0] ACC_CODE_RESET     = 6'h00;
    localparam logic [3:0] ACC_RF_RDATA_RESET = 4'h0;
    localparam logic [15:0] ACC_PER_RDATA_RESET = 16'h0000;

    // Register-file access, 4-bit nibble data
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [6:0] addr;
        logic [3:0] wdata;
    } acc_rf_req_t;

    // Peripheral access, data moves through the 16-bit transfer buffer
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  addr;
        logic [15:0] transfer_buffer;
    } acc_per_req_t;

endpackage

// >>> verification/acc_analog_src.sv
// Analog pins and comparator seen from outside the converter
module acc_analog_src
    import acc_pkg::*;
(
    input  wire logic                      ref_clk_i,
    input  wire logic [ACC_CHAN_COUNT-1:0] chan_route_i,
    input  wire logic [ACC_CODE_WIDTH-1:0] tap_sel_i,
    input  wire logic [5:0]                volt_i [ACC_CHAN_COUNT],
    output logic                           cmp_o
);
    timeunit 1ns;
    timeprecision 100ps;
    logic float_q = 1'b0;

    // Unrouted comparator input floats, so its output wanders
    always @(posedge ref_clk_i) float_q <= ~float_q;

    // Volt in tap steps; true once the pin reaches the tap
    always_comb begin
        cmp_o = float_q;
        for (int n = 0; n < ACC_CHAN_COUNT; n++)
            if (chan_route_i[n]) cmp_o = (volt_i[n] >= tap_sel_i);
    end
endmodule

// >>> verification/adc_channel_compare_control_tb.sv
module adc_channel_compare_control_tb
    import acc_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic ref_clk_i = 0, rst_n_i = 0, ce = 0, cs = 0, cmp;
    acc_rf_req_t rf = '0;
    acc_per_req_t per = '0;
    logic [3:0] pa = 0, rd_d, rd_q, pa_lv, pd;
    logic [1:0] pb = 0, pb_lv;
    logic [15:0] prd;
    logic [5:0] route, tap, code;
    logic [5:0] volt [ACC_CHAN_COUNT] = '{default: 6'h00};
    logic pwr;
    int bad_count = 0, tests_run = 0;

    acc_adc_control i_dut (.ref_clk_i, .rst_n_i, .ce_reset_i(ce),
        .clock_stop_i(cs), .rf_req_i(rf), .rf_rdata_o(rd_q),
        .per_req_i(per), .per_rdata_o(prd), .shared_port_a_i(pa),
        .shared_port_b_i(pb), .shared_port_a_level_o(pa_lv),
        .shared_port_b_level_o(pb_lv), .chan_route_o(route),
        .pulldown_en_o(pd), .tap_sel_o(tap), .rstring_power_o(pwr),
        .comparator_i(cmp));
    acc_analog_src i_src (.ref_clk_i, .chan_route_i(route),
        .tap_sel_i(tap), .volt_i(volt), .cmp_o(cmp));

    // Clock of 25 ns
    initial forever #12.5 ref_clk_i = ~ref_clk_i;

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic tick();
        @(posedge ref_clk_i);
        #1;
    endtask
    task automatic rf_wr(input logic [6:0] a, input logic [3:0] d);
        rf = '{1'b1, 1'b0, a, d};
        tick();
        rf = '0;
        tick();
    endtask
    // String powered only during the judge read cycle
    task automatic rf_rd(input logic [6:0] a, output logic [3:0] d);
        rf = '{1'b0, 1'b1, a, 4'h0};
        #1 chk(16'(pwr), 16'(a == ACC_RF_JUDGE_ADDR));
        tick();
        d = rd_q;
        rf = '0;
        #1 chk(16'(pwr), 16'h0000);
        tick();
    endtask
    task automatic per_wr(input logic [15:0] d);
        per = '{1'b1, 1'b0, ACC_PER_CODE_ADDR, d};
        tick();
        per = '0;
        tick();
    endtask

    task automatic t_reset();
        rf_rd(ACC_RF_CHSEL_ADDR, rd_d);
        chk(16'(rd_d), 16'h0007);
        chk(16'(route), 16'h0000);
        chk(16'(pd), 16'h000f);
        $display("test reset done");
    endtask
    task automatic t_chan();
        logic [5:0] er;
        for (int c = 0; c < 8; c++) begin
            rf_wr(ACC_RF_CHSEL_ADDR, 4'(c) | 4'h8);
            rf_wr(7'h15, 4'h0);
            rf_wr(ACC_RF_JUDGE_ADDR, 4'hf);
            rf_rd(ACC_RF_CHSEL_ADDR, rd_d);
            chk(16'(rd_d), 16'(c));
            er = (c < 6) ? 6'(1 << c) : 6'h00;
            chk(16'(route), 16'(er));
            chk(16'(pd), 16'(4'hf & ~er[5:2]));
            rf_rd(7'h15, rd_d);
            chk(16'(rd_d), 16'h0000);
        end
        $display("test channel done");
    endtask
    // Software successive approximation, six trials per channel
    task automatic t_sar(input int ch, input logic [5:0] v);
        volt[ch] = v;
        rf_wr(ACC_RF_CHSEL_ADDR, 4'(ch));
        code = 6'h00;
        for (int b = 5; b >= 0; b--) begin
            per_wr({10'h3ff, code | 6'(1 << b)});
            chk(16'(tap), 16'(code | 6'(1 << b)));
            rf_rd(ACC_RF_JUDGE_ADDR, rd_d);
            chk(16'(rd_d[3:1]), 16'h0000);
            if (rd_d[0]) code = code | 6'(1 << b);
        end
        chk(16'(code), 16'(v));
        per_wr({10'h3ff, code});
        per = '{1'b0, 1'b1, ACC_PER_CODE_ADDR, 16'h0000};
        tick();
        per = '0;
        chk(prd, {10'h000, v});
        tick();
        $display("test compare done");
    endtask
    // CE reset and clock stop clear the channel, keep the code
    task automatic t_soft();
        for (int i = 0; i < 2; i++) begin
            rf_wr(ACC_RF_CHSEL_ADDR, 4'h2);
            per_wr(16'h0015);
            {cs, ce} = (i == 0) ? 2'b01 : 2'b10;
            tick();
            {cs, ce} = 2'b00;
            rf_rd(ACC_RF_CHSEL_ADDR, rd_d);
            chk(16'(rd_d), 16'h0007);
            chk(16'(route), 16'h0000);
            chk(16'(tap), 16'h0015);
        end
        $display("test soft reset done");
    endtask
    task automatic t_pins();
        rf_wr(ACC_RF_CHSEL_ADDR, 4'h2);
        for (int i = 0; i < 2; i++) begin
            pa = (i == 0) ? 4'ha : 4'h5;
            pb = ~pb;
            tick();
            tick();
            chk(16'(pa_lv), 16'(pa));
            chk(16'(pb_lv), 16'(pb));
            chk(16'(pd), 16'h000e);
        end
        $display("test pins done");
    endtask

    task automatic give_verdict();
        $display("tests_run=%0d bad_count=%0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    // Watchdog against a hang
    initial begin
        repeat (20000) @(posedge ref_clk_i);
        bad_count++;
        give_verdict();
    end
    initial begin
        repeat (16) @(posedge ref_clk_i);
        #1 rst_n_i = 1;
        tick();
        t_reset();
        t_chan();
        t_sar(0, 6'h3f);
        t_sar(4, 6'h2a);
        t_soft();
        t_pins();
        give_verdict();
    end
endmodule
